// ===== inc/psr_pkg.sv
// shared constants and types for the pressure sensor serial readout
// assumes one 125 MHz system clock, a free-running 32 kHz converter clock and a host-driven link
`default_nettype none

package psr_pkg;

	// ************************************************************
	// link framing
	// ************************************************************
	localparam int unsigned START_BITS     = 3;   // consecutive highs opening a frame
	localparam int unsigned STOP_BITS      = 3;   // consecutive lows closing a frame
	localparam int unsigned INSTR_BITS     = 4;
	localparam int unsigned ACK_TAIL_CLKS  = 2;   // clocks the host gives after the ack
	localparam int unsigned WORD_BITS      = 16;
	localparam int unsigned RESET_SEQ_BITS = 21;
	localparam logic [5:0]  CNT_ONE        = 6'h01;

	// ************************************************************
	// instruction and reset patterns (defaults, overridable at the top)
	// ************************************************************
	localparam logic [3:0]  INSTR_PRESSURE_DEF = 4'hA;
	localparam logic [3:0]  INSTR_TEMP_DEF     = 4'h9;
	localparam logic [3:0]  INSTR_CAL13_DEF    = 4'h5;
	localparam logic [3:0]  INSTR_CAL24_DEF    = 4'h6;
	localparam logic [20:0] RESET_SEQ_DEF      = 21'h15_5540;

	// ************************************************************
	// converter timing, counted in converter clock ticks
	// ************************************************************
	localparam int unsigned MCLK_HZ          = 32768;
	localparam int unsigned CONV_TIME_MS     = 35;    // longest conversion
	localparam int unsigned CONV_TICKS       = CONV_TIME_MS * MCLK_HZ / 1000;
	localparam int unsigned BRIDGE_TOTAL_US  = 2000;  // bridge on-time per conversion
	localparam int unsigned BRIDGE_TICKS     = BRIDGE_TOTAL_US * MCLK_HZ / 1000000;
	localparam int unsigned BRIDGE_BURSTS    = 8;
	localparam int unsigned BURST_LEN        = BRIDGE_TICKS / BRIDGE_BURSTS;
	localparam int unsigned BURST_PERIOD     = CONV_TICKS / BRIDGE_BURSTS;

	// ************************************************************
	// result range
	// ************************************************************
	localparam logic [15:0] RESULT_MIN = 16'h1388;  // 5,000 counts
	localparam logic [15:0] RESULT_MAX = 16'h9088;  // 37,000 counts

	// sampled link lines, kept together so both pass the same stages
	typedef struct packed {
		logic sclk;
		logic din;
	} psr_link_t;

	typedef enum logic {
		PSR_ADC_PRESSURE,
		PSR_ADC_TEMPERATURE
	} psr_adc_sel_t;

endpackage : psr_pkg

`default_nettype wire

// ===== src/psr_readout.sv
// control and serial readout logic of a pressure/temperature sensor module
// assumes SCLK, DIN and MCLK arrive asynchronously; samples come from the converter on CLK
`default_nettype none

module psr_readout
	import psr_pkg::*;
#(
	parameter logic [3:0]  INSTR_PRESSURE   = INSTR_PRESSURE_DEF,
	parameter logic [3:0]  INSTR_TEMP       = INSTR_TEMP_DEF,
	parameter logic [3:0]  INSTR_CAL13      = INSTR_CAL13_DEF,
	parameter logic [3:0]  INSTR_CAL24      = INSTR_CAL24_DEF,
	parameter logic [20:0] RESET_SEQ        = RESET_SEQ_DEF,
	parameter logic [15:0] CALIB_WORD_ONE   = 16'h1234,  // factory data, arbitrary value
	parameter logic [15:0] CALIB_WORD_TWO   = 16'h5678,  // factory data, arbitrary value
	parameter logic [15:0] CALIB_WORD_THREE = 16'h9ABC,  // factory data, arbitrary value
	parameter logic [15:0] CALIB_WORD_FOUR  = 16'hDEF0   // factory data, arbitrary value
)
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        SCLK,
	input  wire logic        DIN,
	input  wire logic        MCLK,
	input  wire logic [15:0] PRESSURE_SAMPLE,
	input  wire logic [15:0] TEMPERATURE_SAMPLE,
	output var  logic        DOUT,
	output var  logic        BRIDGE_ON,
	output var  logic        ADC_SEL
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INSTR,
		ST_STOP,
		ST_ACK,
		ST_CONV,
		ST_READ
	} psr_state_t;

	// keeps every result inside the converter's linear window
	function automatic logic [15:0] psr_clamp(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		if (v < RESULT_MIN)
		begin
			r = RESULT_MIN;
		end
		else if (v > RESULT_MAX)
		begin
			r = RESULT_MAX;
		end
		return r;
	endfunction : psr_clamp

	// ************************************************************
	// input synchronisers
	// ************************************************************
	psr_link_t link_s1_reg;
	psr_link_t link_s2_reg;
	logic      sclk_s3_reg;
	logic      mclk_s1_reg;
	logic      mclk_s2_reg;
	logic      mclk_s3_reg;
	logic      sclk_rise;
	logic      sclk_fall;
	logic      mclk_rise;
	logic      din_bit;

	// the first stage feeds only the second; edges are found one stage later
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			link_s1_reg <= '0;
			link_s2_reg <= '0;
			sclk_s3_reg <= 1'b0;
			mclk_s1_reg <= 1'b0;
			mclk_s2_reg <= 1'b0;
			mclk_s3_reg <= 1'b0;
		end
		else
		begin
			link_s1_reg <= '{sclk: SCLK, din: DIN};
			link_s2_reg <= link_s1_reg;
			sclk_s3_reg <= link_s2_reg.sclk;
			mclk_s1_reg <= MCLK;
			mclk_s2_reg <= mclk_s1_reg;
			mclk_s3_reg <= mclk_s2_reg;
		end
	end

	assign sclk_rise = link_s2_reg.sclk & ~sclk_s3_reg;
	assign sclk_fall = ~link_s2_reg.sclk & sclk_s3_reg;
	assign mclk_rise = mclk_s2_reg & ~mclk_s3_reg;
	assign din_bit   = link_s2_reg.din;

	// ************************************************************
	// reset sequence watcher
	// ************************************************************
	logic [20:0] rx_hist_reg;
	logic [20:0] rx_hist_next;
	logic        seq_reset;

	// every received bit is watched, whatever the protocol state
	assign rx_hist_next = {rx_hist_reg[19:0], din_bit};
	assign seq_reset    = sclk_rise && (rx_hist_next == RESET_SEQ);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rx_hist_reg <= '0;
		end
		else if (seq_reset)
		begin
			rx_hist_reg <= '0;  // avoids a second match on overlapping bits
		end
		else if (sclk_rise)
		begin
			rx_hist_reg <= rx_hist_next;
		end
	end

	// ************************************************************
	// protocol state machine
	// ************************************************************
	psr_state_t   state_reg;
	logic [5:0]   bit_cnt_reg;
	logic [3:0]   instr_reg;
	logic [31:0]  shift_reg;
	logic         dout_reg;
	logic         is_conv;
	logic         is_cal;
	logic         conv_done;
	logic [15:0]  sample_sel;
	psr_adc_sel_t adc_sel_reg;

	assign is_conv = (instr_reg == INSTR_PRESSURE) || (instr_reg == INSTR_TEMP);
	assign is_cal  = (instr_reg == INSTR_CAL13) || (instr_reg == INSTR_CAL24);
	assign sample_sel = (adc_sel_reg == PSR_ADC_PRESSURE) ? PRESSURE_SAMPLE
		: TEMPERATURE_SAMPLE;

	// state, counters and instruction bits advance on serial clock rises; the end of conversion moves state and count on a converter clock rise
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= '0;
			instr_reg   <= '0;
			adc_sel_reg <= PSR_ADC_PRESSURE;
		end
		else if (seq_reset)
		begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (sclk_rise)
					begin
						if (!din_bit)
						begin
							bit_cnt_reg <= '0;
						end
						else if (bit_cnt_reg == 6'(START_BITS - 1))
						begin
							state_reg   <= ST_INSTR;
							bit_cnt_reg <= '0;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
						end
					end
				end
				ST_INSTR:
				begin
					if (sclk_rise)
					begin
						instr_reg   <= {instr_reg[2:0], din_bit};
						bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
						if (bit_cnt_reg == 6'(INSTR_BITS - 1))
						begin
							state_reg   <= ST_STOP;
							bit_cnt_reg <= '0;
						end
					end
				end
				ST_STOP:
				begin
					if (sclk_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
						if (din_bit || !(is_conv || is_cal))
						begin
							state_reg   <= ST_IDLE;
							bit_cnt_reg <= '0;
						end
						else if (bit_cnt_reg == 6'(STOP_BITS - 1))
						begin
							bit_cnt_reg <= '0;
							if (is_conv)
							begin
								state_reg   <= ST_ACK;
								adc_sel_reg <= (instr_reg == INSTR_PRESSURE)
									? PSR_ADC_PRESSURE : PSR_ADC_TEMPERATURE;
							end
							else
							begin
								state_reg   <= ST_READ;
								bit_cnt_reg <= 6'(2 * WORD_BITS);
							end
						end
					end
				end
				ST_ACK:
				begin
					if (sclk_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
						if (bit_cnt_reg == 6'(ACK_TAIL_CLKS - 1))
						begin
							state_reg   <= ST_CONV;
							bit_cnt_reg <= '0;
						end
					end
				end
				ST_CONV:
				begin
					if (conv_done)
					begin
						state_reg   <= ST_READ;
						bit_cnt_reg <= 6'(WORD_BITS);
					end
				end
				ST_READ:
				begin
					// a held serial clock simply leaves the count where it is
					if (sclk_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg - CNT_ONE;
						if (bit_cnt_reg == CNT_ONE)
						begin
							state_reg   <= ST_IDLE;
							bit_cnt_reg <= '0;
						end
					end
				end
				default:
				begin
					state_reg   <= ST_IDLE;
					bit_cnt_reg <= '0;
				end
			endcase
		end
	end

	// ************************************************************
	// output shifter and data line
	// ************************************************************
	// the data line rises only on falling serial edges; it falls on serial edges of either sense or on conversion end
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			shift_reg <= '0;
			dout_reg  <= 1'b0;
		end
		else if (seq_reset)
		begin
			dout_reg <= 1'b0;
		end
		else if (state_reg == ST_STOP && sclk_rise && !din_bit
			&& bit_cnt_reg == 6'(STOP_BITS - 1) && is_cal)
		begin
			// words one/three or two/four leave back to back, msb first
			shift_reg <= (instr_reg == INSTR_CAL13)
				? {CALIB_WORD_ONE, CALIB_WORD_THREE}
				: {CALIB_WORD_TWO, CALIB_WORD_FOUR};
		end
		else if (state_reg == ST_STOP && sclk_fall
			&& bit_cnt_reg == 6'(STOP_BITS - 1) && is_conv)
		begin
			dout_reg <= 1'b1;
		end
		else if (conv_done)
		begin
			shift_reg <= {psr_clamp(sample_sel), 16'h0000};
			dout_reg  <= 1'b0;
		end
		else if (state_reg == ST_READ && sclk_fall)
		begin
			dout_reg  <= shift_reg[31];
			shift_reg <= {shift_reg[30:0], 1'b0};
		end
		else if (state_reg == ST_IDLE)
		begin
			dout_reg <= 1'b0;
		end
	end

	// ************************************************************
	// conversion timer and bridge power
	// ************************************************************
	logic [10:0] conv_cnt_reg;
	logic [7:0]  burst_cnt_reg;
	logic        bridge_reg;

	assign conv_done = (state_reg == ST_CONV) && mclk_rise
		&& (conv_cnt_reg == 11'(CONV_TICKS - 1));

	// counts converter ticks only while a conversion is running
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			conv_cnt_reg  <= '0;
			burst_cnt_reg <= '0;
		end
		else if (state_reg != ST_CONV || seq_reset)
		begin
			conv_cnt_reg  <= '0;
			burst_cnt_reg <= '0;
		end
		else if (mclk_rise)
		begin
			conv_cnt_reg <= conv_cnt_reg + 11'h001;
			if (burst_cnt_reg == 8'(BURST_PERIOD - 1))
			begin
				burst_cnt_reg <= '0;
			end
			else
			begin
				burst_cnt_reg <= burst_cnt_reg + 8'h01;
			end
		end
	end

	// short bursts at the head of each period; eight of them add up to about 2 ms
	// the tail after the eighth period is left dark so no ninth burst stretches the total
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			bridge_reg <= 1'b0;
		end
		else
		begin
			bridge_reg <= (state_reg == ST_CONV) && !seq_reset
				&& (conv_cnt_reg < 11'(BRIDGE_BURSTS * BURST_PERIOD))
				&& (burst_cnt_reg < 8'(BURST_LEN));
		end
	end

	assign DOUT      = dout_reg;
	assign BRIDGE_ON = bridge_reg;
	assign ADC_SEL   = adc_sel_reg;

endmodule : psr_readout

`default_nettype wire

// ===== verif/psr_readout_monitor.sv
// checker on the readout top ports, bound after the module
// assumes link and converter edges lie at least 4 CLK apart
`default_nettype none
module psr_readout_monitor
	import psr_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        SCLK,
	input wire logic        DIN,
	input wire logic        MCLK,
	input wire logic [15:0] PRESSURE_SAMPLE,
	input wire logic [15:0] TEMPERATURE_SAMPLE,
	input wire logic        DOUT,
	input wire logic        BRIDGE_ON,
	input wire logic        ADC_SEL
);
	// ************************************************************
	// edge ages
	// ************************************************************
	logic [1:0] sc_reg;    // synced serial clock, newest in bit 0
	logic [1:0] mc_reg;    // synced converter clock
	logic [3:0] fall_reg;  // cycles since a serial clock fall
	logic [3:0] edge_reg;  // cycles since any serial clock edge
	logic [3:0] mrise_reg; // cycles since a converter clock rise
	// ages saturate so a long idle never wraps into a false recent edge
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sc_reg    <= 2'h0;
			mc_reg    <= 2'h0;
			fall_reg  <= 4'hF;
			edge_reg  <= 4'hF;
			mrise_reg <= 4'hF;
		end
		else
		begin
			sc_reg    <= {sc_reg[0], SCLK};
			mc_reg    <= {mc_reg[0], MCLK};
			fall_reg  <= (sc_reg == 2'h2) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hF};
			edge_reg  <= (^sc_reg) ? 4'h0 : edge_reg + {3'h0, edge_reg != 4'hF};
			mrise_reg <= (mc_reg == 2'h1) ? 4'h0 : mrise_reg + {3'h0, mrise_reg != 4'hF};
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence s_burst;
		BRIDGE_ON [*8];
	endsequence
	AST_DOUT_RISE_AT_FALL: assert property ($rose(DOUT) |-> fall_reg <= 4'h7)
		else $error("output rose away from a serial clock fall");
	AST_DOUT_FALL_CAUSE: assert property ($fell(DOUT) |-> edge_reg <= 4'h7 || mrise_reg <= 4'h7)
		else $error("output fell with no link or converter edge");
	AST_BRIDGE_BURST: assert property ($rose(BRIDGE_ON) |-> s_burst)
		else $error("bridge burst too short");
	AST_BRIDGE_RISE_MCLK: assert property ($rose(BRIDGE_ON) |-> mrise_reg <= 4'h7 || edge_reg <= 4'h7)
		else $error("bridge switched on off the converter tick");
	AST_BRIDGE_FALL_MCLK: assert property ($fell(BRIDGE_ON) |-> mrise_reg <= 4'h7)
		else $error("bridge switched off off the converter tick");
	AST_BRIDGE_IN_CONV: assert property (BRIDGE_ON |-> DOUT || $past(DOUT))
		else $error("bridge powered outside a conversion");
	AST_SEL_STEADY: assert property (BRIDGE_ON |-> $stable(ADC_SEL))
		else $error("converter input moved while bridge on");
	AST_SEL_BY_INSTR: assert property ($changed(ADC_SEL) |-> edge_reg <= 4'h7)
		else $error("converter input moved with no instruction");
endmodule : psr_readout_monitor
bind psr_readout psr_readout_monitor psr_readout_monitor_inst (
	.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .DIN(DIN), .MCLK(MCLK),
	.PRESSURE_SAMPLE(PRESSURE_SAMPLE), .TEMPERATURE_SAMPLE(TEMPERATURE_SAMPLE),
	.DOUT(DOUT), .BRIDGE_ON(BRIDGE_ON), .ADC_SEL(ADC_SEL)
);
`default_nettype wire

// ===== verif/psr_host.sv
// host model driving the three-wire link, 64 ns serial clock
// assumes callers enter its tasks just after a CLK edge
`default_nettype none
module psr_host
	import psr_pkg::*;
(
	input  wire logic clk,
	input  wire logic dout,
	output var  logic sclk,
	output var  logic din
);
	timeunit 1ns;
	timeprecision 100ps;
	// serial clock idles high and stands still between frames
	initial
	begin
		sclk = 1'b1;
		din  = 1'b0;
	end
	// one clock: data set at the fall, taken at the rise, read late in high half
	task automatic bit_io(input logic b, output logic q);
		sclk = 1'b0;
		din  = b;
		#32 sclk = 1'b1;
		#28 q = dout;
		#4;
	endtask : bit_io
	// start, instruction msb first, stop; the last read shows the ack
	task automatic frame(input logic [3:0] op, output logic ack);
		logic [9:0] f;
		f = {3'h7, op, 3'h0};
		for (int i = 9; i >= 0; i--) bit_io(f[i], ack);
	endtask : frame
	// two clocks after the ack, then a bounded wait for the end of conversion
	task automatic tail(output logic ok);
		logic q;
		bit_io(1'b0, q);
		bit_io(1'b0, q);
		ok = 1'b0;
		for (int i = 0; i < 12000 && !ok; i++)
		begin
			@(posedge clk);
			ok = (dout === 1'b0);
		end
		#1;
	endtask : tail
	// a whole word is always taken; the pause holds the clock high mid-word
	task automatic read16(output logic [15:0] w, input int pause_at);
		for (int i = 15; i >= 0; i--)
		begin
			if (i == pause_at) #400;
			bit_io(1'b0, w[i]);
		end
	endtask : read16
	task automatic rst21();
		logic q;
		for (int i = 20; i >= 0; i--) bit_io(RESET_SEQ_DEF[i], q);
	endtask : rst21
endmodule : psr_host
`default_nettype wire

// ===== verif/psr_readout_test.sv
// self-checking bench: host model, converter clock and sample values
// assumes the design defaults for instruction and reset patterns
`default_nettype none
module psr_readout_test;
	import psr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] W1 = 16'h3C5A;
	localparam logic [15:0] W2 = 16'hA1E7;
	localparam logic [15:0] W3 = 16'h0F96;
	localparam logic [15:0] W4 = 16'h7B2D;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        mclk = 1'b0;
	logic        sclk, din, dout, bridge_on, adc_sel, sel_seen;
	logic [15:0] p_smp = 16'h0000;
	logic [15:0] t_smp = 16'h0000;
	logic [15:0] exp_q[$];
	int          bad_count = 0;
	int          checks = 0;
	int          br_cnt = 0;
	// ************************************************************
	// clocks, parts, watchers
	// ************************************************************
	always #4 clk = ~clk;
	// converter clock offset from CLK so its edges never meet a CLK edge
	initial
	begin
		#3;
		forever #32 mclk = ~mclk;
	end
	psr_readout #(.CALIB_WORD_ONE(W1), .CALIB_WORD_TWO(W2), .CALIB_WORD_THREE(W3),
		.CALIB_WORD_FOUR(W4)) psr_readout_inst (.CLK(clk), .RESETN(resetn), .SCLK(sclk),
		.DIN(din), .MCLK(mclk), .PRESSURE_SAMPLE(p_smp), .TEMPERATURE_SAMPLE(t_smp),
		.DOUT(dout), .BRIDGE_ON(bridge_on), .ADC_SEL(adc_sel));
	psr_host psr_host_inst (.clk(clk), .dout(dout), .sclk(sclk), .din(din));
	// bridge on-time and converter input as seen during bursts
	always @(posedge clk)
	begin
		if (bridge_on === 1'b1) br_cnt++;
		if (bridge_on === 1'b1) sel_seen <= adc_sel;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// model: the result word is the sample held inside the linear range
	function automatic logic [15:0] clamp(input int v);
		return (v < RESULT_MIN) ? RESULT_MIN : (v > RESULT_MAX) ? RESULT_MAX : 16'(v);
	endfunction : clamp
	task automatic run_conv(input logic [3:0] op, input logic sel, input int v, input int pz);
		logic        ack, ok;
		logic [15:0] w;
		exp_q.push_back(clamp(v));
		@(posedge clk);
		#1;
		if (sel) t_smp = 16'(v);
		else p_smp = 16'(v);
		br_cnt = 0;
		psr_host_inst.frame(op, ack);
		check({15'h0, ack}, 16'h0001, "ack");
		psr_host_inst.tail(ok);
		check({15'h0, ok}, 16'h0001, "end of conversion");
		if (!ok) close_out();
		check({15'h0, sel_seen}, {15'h0, sel}, "converter input");
		check({15'h0, br_cnt inside {[496:528]}}, 16'h0001, "bridge time");
		psr_host_inst.read16(w, pz);
		check(w, exp_q.pop_front(), "result");
		$display("test conversion %h done", op);
	endtask : run_conv
	task automatic run_cal(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b);
		logic        ack;
		logic [15:0] w;
		@(posedge clk);
		#1;
		psr_host_inst.frame(op, ack);
		check({15'h0, ack}, 16'h0000, "no ack");
		psr_host_inst.read16(w, 99);
		check(w, a, "first word");
		psr_host_inst.read16(w, 3);
		check(w, b, "second word");
		$display("test calibration %h done", op);
	endtask : run_cal
	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin : main
		logic       q;
		logic [6:0] pre;
		void'($urandom(32'hf931));
		repeat (2) @(posedge clk);
		check({13'h0, dout, bridge_on, adc_sel}, 16'h0000, "reset state");
		#1 resetn = 1'b1;
		repeat (4) @(posedge clk);
		run_cal(INSTR_CAL13_DEF, W1, W3);
		run_cal(INSTR_CAL24_DEF, W2, W4);
		run_conv(INSTR_PRESSURE_DEF, 1'b0, 5000 + $urandom % 32001, 7);
		run_conv(INSTR_TEMP_DEF, 1'b1, $urandom % 5000, 99);
		run_conv(INSTR_PRESSURE_DEF, 1'b0, 37001 + $urandom % 28534, 0);
		// unknown instruction: no ack, output stays low
		psr_host_inst.frame(4'hF, q);
		repeat (20) @(posedge clk);
		check({14'h0, q, dout}, 16'h0000, "unknown instruction");
		// protocol reset after a broken frame, then normal service again
		#1 pre = 7'h75;
		for (int i = 6; i >= 0; i--) psr_host_inst.bit_io(pre[i], q);
		psr_host_inst.rst21();
		repeat (6) @(posedge clk);
		check({15'h0, dout}, 16'h0000, "after reset sequence");
		run_cal(INSTR_CAL13_DEF, W1, W3);
		$display("test protocol reset done");
		close_out();
	end : main
endmodule : psr_readout_test
`default_nettype wire
